// >>> verilog/asc_ctrl.v
// host-side controller driving an asynchronous static memory over its pins
// ============================================================
// Overview of operation
// - start write only with write strobe, both selects and a lane enable active.
// - write data stands 25 ns before terminating edge, held to it.
// - address stable 35 ns before write end, set before start, cycle 45 ns.
// - address may change right after the terminating edge.
// - selects and lane enables active 35 ns before end; strobe 35 ns wide.
// - strobe-controlled write with output strobe low lasts at least 25+18 ns.
// - deselect by a chip select or both lane enables high.
// - write strobe stays high through every read.
// - address valid before or with selects and lane enables in reads.
// - controller never drives data while memory may still drive it.
`default_nettype none
`include "asc_timing_map.vh"

module asc_ctrl #(
    parameter AW = 20,
    parameter DW = 16
) (
    input  wire          sys_clk,
    input  wire          rstn,
    input  wire          req_valid,
    input  wire          req_write,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_wdata,
    input  wire [1:0]    req_lane_n,
    output reg           req_ready_r,
    output reg           rsp_valid_r,
    output reg  [DW-1:0] rsp_rdata_r,
    output reg  [AW-1:0] mem_addr_r,
    output reg           chip_select_n_r,
    output reg           chip_select_hi_r,
    output reg           write_strobe_n_r,
    output reg           output_strobe_n_r,
    output reg           upper_byte_en_n_r,
    output reg           lower_byte_en_n_r,
    input  wire [DW-1:0] mem_data_in,
    output reg  [DW-1:0] mem_data_out_r,
    output reg           mem_data_oe_r
);
    // phase encoding of the cycle sequencer
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_WSET  = 3'h1;
    localparam [2:0] ST_WLOW  = 3'h2;
    localparam [2:0] ST_WEND  = 3'h3;
    localparam [2:0] ST_RD    = 3'h4;
    localparam [2:0] ST_RGAP  = 3'h5;

    localparam CW = 5;
    // phase lengths rounded up to whole cycles, then cut to the timer width
    localparam integer  WE_LOW_INT = `ASC_CYC_UP(`ASC_WE_LOW_NS);
    localparam integer  WC_INT     = `ASC_CYC_UP(`ASC_T_WC_NS);
    localparam integer  RD_INT     = `ASC_CYC_UP(`ASC_T_AA_NS);
    localparam integer  HZ_INT     = `ASC_CYC_UP(`ASC_T_HZ_NS);
    localparam [CW-1:0] WE_LOW_CYC = WE_LOW_INT[CW-1:0];
    localparam [CW-1:0] WC_CYC     = WC_INT[CW-1:0];
    localparam [CW-1:0] RD_CYC     = RD_INT[CW-1:0];
    localparam [CW-1:0] HZ_CYC     = HZ_INT[CW-1:0];

    reg [2:0]    state_r;
    reg [2:0]    state_nxt;
    reg          ld;
    reg [CW-1:0] ld_val;
    reg [CW-1:0] wlow_r;
    wire         tmr_done;
    wire         take;

    // ============================================================
    // a request is taken only with a lane enabled; others wait, never dropped
    assign take = req_valid && req_ready_r && (req_lane_n != `ASC_NO_LANES);

    // ============================================================
    // phase timer
    // one timer serves the write cycle, read access and gap phases; the strobe width counts in wlow_r; a load restarts it
    asc_delay_cnt #(
        .W (CW)
    ) u_tmr (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .load     (ld),
        .load_val (ld_val),
        .done_r   (tmr_done)
    );

    // ============================================================
    // next state; the timer loads on leaving idle and on entering the gap phase
    always @* begin
        state_nxt = state_r;
        ld        = 1'b0;
        ld_val    = {CW{1'b0}};
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = req_write ? ST_WSET : ST_RD;
                    ld        = 1'b1;
                    ld_val    = req_write ? WC_CYC : RD_CYC;
                end
            end
            ST_WSET: begin
                state_nxt = ST_WLOW; // address set before strobe falls
            end
            ST_WLOW: begin
                // the strobe pulse count and the cycle timer must both run out
                if (tmr_done && (wlow_r == {CW{1'b0}})) begin
                    state_nxt = ST_WEND;
                end
            end
            ST_WEND: begin
                state_nxt = ST_IDLE;
            end
            ST_RD: begin
                if (tmr_done) begin
                    state_nxt = ST_RGAP;
                    ld        = 1'b1;
                    ld_val    = HZ_CYC;
                end
            end
            ST_RGAP: begin
                // memory may still drive the data pins while its outputs turn off
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // state, pins and handshake registers
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // pins idle: selects off, strobes and lane enables high, bus released
            state_r           <= ST_IDLE;
            wlow_r            <= {CW{1'b0}};
            req_ready_r       <= 1'b0;
            rsp_valid_r       <= 1'b0;
            rsp_rdata_r       <= {DW{1'b0}};
            mem_addr_r        <= {AW{1'b0}};
            chip_select_n_r   <= `ASC_INACT_LO;
            chip_select_hi_r  <= 1'b0;
            write_strobe_n_r  <= `ASC_INACT_LO;
            output_strobe_n_r <= `ASC_INACT_LO;
            upper_byte_en_n_r <= `ASC_INACT_LO;
            lower_byte_en_n_r <= `ASC_INACT_LO;
            mem_data_out_r    <= {DW{1'b0}};
            mem_data_oe_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            rsp_valid_r <= 1'b0;
            // ready returns once the sequencer heads back to idle without taking
            req_ready_r <= (state_nxt == ST_IDLE) && !(state_r == ST_IDLE && ld);
            case (state_r)
                ST_IDLE: begin
                    if (ld) begin
                        // address, lane enables and selects all change together
                        mem_addr_r        <= req_addr;
                        upper_byte_en_n_r <= req_lane_n[1];
                        lower_byte_en_n_r <= req_lane_n[0];
                        chip_select_n_r   <= `ASC_ACT_LO;
                        chip_select_hi_r  <= 1'b1;
                        write_strobe_n_r  <= `ASC_INACT_LO;
                        output_strobe_n_r <= req_write ? `ASC_INACT_LO : `ASC_ACT_LO;
                        mem_data_out_r    <= req_wdata;
                    end
                end
                ST_WSET: begin
                    // bus is quiet: output strobe high keeps memory off the data pins
                    write_strobe_n_r <= `ASC_ACT_LO;
                    mem_data_oe_r    <= 1'b1;
                    wlow_r           <= WE_LOW_CYC;
                end
                ST_WLOW: begin
                    if (wlow_r != {CW{1'b0}}) begin
                        wlow_r <= wlow_r - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                ST_WEND: begin
                    // strobe rise terminates the write; data held through it
                    // address and data pins stay put on this edge
                    write_strobe_n_r  <= `ASC_INACT_LO;
                    chip_select_n_r   <= `ASC_INACT_LO;
                    chip_select_hi_r  <= 1'b0;
                    upper_byte_en_n_r <= `ASC_INACT_LO;
                    lower_byte_en_n_r <= `ASC_INACT_LO;
                end
                ST_RD: begin
                    // access time is over: capture, and on the same edge release output strobe, selects and lane enables
                    if (tmr_done) begin
                        rsp_rdata_r       <= mem_data_in;
                        rsp_valid_r       <= 1'b1;
                        output_strobe_n_r <= `ASC_INACT_LO;
                        chip_select_n_r   <= `ASC_INACT_LO;
                        chip_select_hi_r  <= 1'b0;
                        upper_byte_en_n_r <= `ASC_INACT_LO;
                        lower_byte_en_n_r <= `ASC_INACT_LO;
                    end
                end
                default: begin
                    mem_data_oe_r <= mem_data_oe_r;
                end
            endcase
            // release data one cycle after the terminating edge, back in idle,
            // so the data never moves together with the strobe rise
            if (state_r == ST_IDLE) begin
                mem_data_oe_r <= 1'b0;
            end
        end
    end
endmodule // asc_ctrl

`default_nettype wire

// >>> verilog/asc_timing_map.vh
// timing constants and pin-level encodings for the async memory controller
`ifndef ASC_TIMING_MAP_VH
`define ASC_TIMING_MAP_VH

// clock period in ns
`define ASC_CLK_NS       4
// minimum times in ns, as the memory requires them
`define ASC_T_WC_NS      45
`define ASC_T_RC_NS      45
`define ASC_T_PWE_NS     35
`define ASC_T_SD_NS      25
`define ASC_T_HZWE_NS    18
`define ASC_T_AA_NS      45
`define ASC_T_HZ_NS      18
// counts in cycles: least times round up
`define ASC_CYC_UP(t)    (((t) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
// write strobe held low long enough for pulse width and data setup plus turn-off
`define ASC_WE_LOW_NS    (((`ASC_T_PWE_NS) > (`ASC_T_SD_NS + `ASC_T_HZWE_NS)) ? \
                          (`ASC_T_PWE_NS) : (`ASC_T_SD_NS + `ASC_T_HZWE_NS))
// pin levels
`define ASC_ACT_LO       1'b0
`define ASC_INACT_LO     1'b1
`define ASC_LANES        2
// lane enable pattern that selects no byte lane at all
`define ASC_NO_LANES     2'h3

`endif

// >>> verilog/asc_delay_cnt.v
// down-counter that marks the end of a timed phase
`default_nettype none

module asc_delay_cnt #(
    parameter W = 5
) (
    input  wire         sys_clk,
    input  wire         rstn,
    input  wire         load,
    input  wire [W-1:0] load_val,
    output reg          done_r
);
    reg [W-1:0] cnt_r;

    // ============================================================
    // counter: load starts a phase, done when count expires
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= {W{1'b0}};
            done_r <= 1'b1;
        end else if (load) begin
            cnt_r  <= load_val;
            done_r <= 1'b0;
        end else if (cnt_r != {W{1'b0}}) begin
            cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
        end else begin
            done_r <= 1'b1;
        end
    end
endmodule // asc_delay_cnt

`default_nettype wire

// >>> verification/asc_ctrl_chk.sv
// pin-level assertions for the async memory controller
`default_nettype none
// ============================================================
// checker
module asc_ctrl_chk #(
    parameter AW = 20
) (
    input wire logic          sys_clk,
    input wire logic          rstn,
    input wire logic          rsp_valid_r,
    input wire logic [AW-1:0] mem_addr_r,
    input wire logic          chip_select_n_r,
    input wire logic          chip_select_hi_r,
    input wire logic          write_strobe_n_r,
    input wire logic          output_strobe_n_r,
    input wire logic          upper_byte_en_n_r,
    input wire logic          lower_byte_en_n_r,
    input wire logic          mem_data_oe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // shorthands for the strobes and the lane term
    wire logic we_n    = write_strobe_n_r;
    wire logic oe_n    = output_strobe_n_r;
    wire logic lane_on = !(upper_byte_en_n_r && lower_byte_en_n_r);
    a_write_window: assert property (
        $fell(we_n) |-> !chip_select_n_r && chip_select_hi_r && lane_on) else $error("bad window");
    a_strobe_width: assert property (
        $fell(we_n) |-> !we_n [*8] ##1 !we_n) else $error("strobe too short");
    a_write_length: assert property (
        $fell(we_n) |-> !we_n [*8] ##1 !we_n [*3]) else $error("write pulse under setup plus float");
    a_sel_hold: assert property (
        !we_n |-> $stable({chip_select_n_r, chip_select_hi_r, upper_byte_en_n_r,
        lower_byte_en_n_r})) else $error("select moved in write");
    a_addr_hold: assert property (
        !we_n |-> $stable(mem_addr_r)) else $error("address moved in write");
    a_data_setup: assert property (
        $rose(we_n) |-> mem_data_oe_r && $past(mem_data_oe_r, 7)) else $error("data setup short");
    a_read_no_write: assert property (
        !oe_n |-> we_n) else $error("write strobe low in read");
    a_no_contention: assert property (
        mem_data_oe_r |-> oe_n) else $error("data driven in read");
    a_read_access: assert property (
        $fell(oe_n) |-> !rsp_valid_r [*8] ##1 !rsp_valid_r [*4] ##[1:2] rsp_valid_r)
        else $error("read answer off time");
    a_turnaround_gap: assert property (
        $rose(oe_n) |-> (oe_n && we_n) [*5]) else $error("turnaround gap short");
    c_read: cover property ($rose(rsp_valid_r));
    c_upper_write: cover property ($fell(we_n) && lower_byte_en_n_r);
    c_lower_write: cover property ($fell(we_n) && upper_byte_en_n_r);
endmodule // asc_ctrl_chk
bind asc_ctrl asc_ctrl_chk #(.AW(AW)) asc_ctrl_chk_inst (.sys_clk, .rstn, .rsp_valid_r,
    .mem_addr_r, .chip_select_n_r, .chip_select_hi_r, .write_strobe_n_r, .output_strobe_n_r,
    .upper_byte_en_n_r, .lower_byte_en_n_r, .mem_data_oe_r);
`default_nettype wire

// >>> verification/asc_mem_model.sv
// behavioural async memory on the far side of the controller pins
`default_nettype none
// ============================================================
// memory model
module asc_mem_model (
    input wire logic [19:0]  mem_addr_r,
    input wire logic         chip_select_n_r,
    input wire logic         chip_select_hi_r,
    input wire logic         write_strobe_n_r,
    input wire logic         output_strobe_n_r,
    input wire logic         upper_byte_en_n_r,
    input wire logic         lower_byte_en_n_r,
    input wire logic [15:0]  bus,
    output wire logic [15:0] mem_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:15] = '{default: 16'h0000};
    wire logic        sel = !chip_select_n_r && chip_select_hi_r;
    wire logic        rd  = sel && !output_strobe_n_r && write_strobe_n_r;
    wire logic        wr  = sel && !write_strobe_n_r;
    wire logic [15:0] q   = mem[mem_addr_r[3:0]];
    // enabled lanes show stored data after the access time, others the inverse
    assign #20 mem_q = {rd && !upper_byte_en_n_r ? q[15:8] : ~q[15:8],
                        rd && !lower_byte_en_n_r ? q[7:0] : ~q[7:0]};
    // enabled lanes follow the pins while the write window stays open
    always @* begin
        if (wr && !upper_byte_en_n_r) mem[mem_addr_r[3:0]][15:8] = bus[15:8];
        if (wr && !lower_byte_en_n_r) mem[mem_addr_r[3:0]][7:0] = bus[7:0];
    end
endmodule // asc_mem_model
`default_nettype wire

// >>> verification/tb_async_sram_cycle_timing.sv
// self-checking bench for the async memory controller
`default_nettype none
// ============================================================
// bench
module tb_async_sram_cycle_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_lane_n = 2'b11;
    logic [31:0] lfsr = 32'hEE9143F6;
    logic [15:0] shadow [0:15] = '{default: 16'h0000};
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;
    wire logic        req_ready_r, rsp_valid_r, chip_select_n_r, chip_select_hi_r, mem_data_oe_r;
    wire logic        write_strobe_n_r, output_strobe_n_r, upper_byte_en_n_r, lower_byte_en_n_r;
    wire logic [15:0] rsp_rdata_r, mem_data_out_r, mem_q, bus;
    wire logic [19:0] mem_addr_r;
    // level of the shared data pins
    assign bus = mem_data_oe_r ? mem_data_out_r : mem_q;
    asc_ctrl asc_ctrl_inst (.sys_clk, .rstn, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_lane_n, .req_ready_r, .rsp_valid_r, .rsp_rdata_r, .mem_addr_r, .chip_select_n_r,
        .chip_select_hi_r, .write_strobe_n_r, .output_strobe_n_r, .upper_byte_en_n_r,
        .lower_byte_en_n_r, .mem_data_in(bus), .mem_data_out_r, .mem_data_oe_r);
    asc_mem_model asc_mem_model_inst (.mem_addr_r, .chip_select_n_r, .chip_select_hi_r,
        .write_strobe_n_r, .output_strobe_n_r, .upper_byte_en_n_r, .lower_byte_en_n_r,
        .bus, .mem_q);
    // clock and hang limit
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one request through the handshake; reads compared on enabled lanes only
    task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                          input logic [1:0] ln);
        logic [15:0] m;
        m = {{8{!ln[1]}}, {8{!ln[0]}}};
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lane_n = ln;
        while (req_ready_r !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        if (wr)
            shadow[a[3:0]] = (shadow[a[3:0]] & ~m) | (d & m);
        else begin
            while (rsp_valid_r !== 1'b1) @(negedge sys_clk);
            check(rsp_rdata_r & m, shadow[a[3:0]] & m);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        // each lane pattern with a lane enabled written, then the whole word read back to back
        for (int k = 0; k < 3; k++) begin
            lfsr = step(lfsr);
            access(1'b1, lfsr[19:0], lfsr[31:16], k[1:0]);
            access(1'b0, lfsr[19:0], 16'h0000, 2'b00);
        end
        // random reads and writes
        for (int k = 0; k < 60; k++) begin
            lfsr = step(lfsr);
            access(lfsr[0], lfsr[20:1], lfsr[31:16], lfsr[22:21] == 2'b11 ? 2'b00 : lfsr[22:21]);
        end
        // no lane enabled: no cycle may start
        while (req_ready_r !== 1'b1) @(negedge sys_clk);
        req_valid = 1'b1;
        req_lane_n = 2'b11;
        repeat (25) begin
            @(negedge sys_clk);
            check({13'h0, req_ready_r, write_strobe_n_r, output_strobe_n_r}, 16'h0007);
        end
        req_valid = 1'b0;
        tally_and_finish();
    end
endmodule // tb_async_sram_cycle_timing
`default_nettype wire
